// [hdl/eamc_top.sv]
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module eamc_top
    import eamc_pkg::*;
(
    input  wire logic                        aclk,     // core clock 20 MHz
    input  wire logic                        aresetn,  // sync reset, low
    input  wire logic [eamc_pkg::ADDR_W-1:0] awaddr,   // write address
    input  wire logic                        awvalid,  // write addr valid
    output logic                             awready,  // write addr ready
    input  wire logic [eamc_pkg::DATA_W-1:0] wdata,    // write data
    input  wire logic [3:0]                  wstrb,    // byte enables
    input  wire logic                        wvalid,   // write data valid
    output logic                             wready,   // write data ready
    output logic [1:0]                       bresp,    // write response
    output logic                             bvalid,   // response valid
    input  wire logic                        bready,   // response ready
    input  wire logic [eamc_pkg::ADDR_W-1:0] araddr,   // read address
    input  wire logic                        arvalid,  // read addr valid
    output logic                             arready,  // read addr ready
    output logic [eamc_pkg::DATA_W-1:0]      rdata,    // read data
    output logic [1:0]                       rresp,    // read response
    output logic                             rvalid,   // read data valid
    input  wire logic                        rready,   // read data ready
    input  wire eamc_pkg::eamc_sample_s      sample,   // dsp power samples
    input  wire logic [2:0]                  zx_pulse, // crossings a, b, c
    output logic                             irq       // level interrupt
);
    import eamc_pkg::*;

    typedef struct packed {
        logic [7:0]        mode;
        logic [7:0]        acfg;
        logic [31:0]       mask;
        logic [31:0]       status;
        logic [15:0]       lc_len;
        logic [15:0]       zx_cnt;
        logic              aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_held;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        eamc_rd_e          rd_st;
        logic [ADDR_W-1:0] ar_addr;
        logic              arready;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              rvalid;
        logic              irq;
    } eamc_top_s;

    eamc_top_s            s_q;
    eamc_top_s            s_d;
    logic [NUM_ACC-1:0]   lc_vec;
    logic                 period_end;
    logic                 bank_rd_req;
    logic [IDX_W-1:0]     bank_idx;
    logic [ACC_W-1:0]     bank_data;
    logic                 ar_energy;
    logic [ADDR_W-1:0]    ar_off;

    // ==========================================================
    // byte-lane merge for register writes
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[8*b +: 8] = nw[8*b +: 8];
        return r;
    endfunction : wmerge

    // ==========================================================
    // group mode bits fanned out to the slots
    assign lc_vec = {{3{s_q.mode[LC_APPARENT_BIT]}},
                     {6{s_q.mode[LC_REACTIVE_BIT]}},
                     {6{s_q.mode[LC_ACTIVE_BIT]}}};

    // energy window decode of the held read address
    assign ar_off      = s_q.ar_addr - ENERGY_BASE;
    assign ar_energy   = (s_q.ar_addr >= ENERGY_BASE) &&
                         (s_q.ar_addr <= ENERGY_END) &&
                         (s_q.ar_addr[1:0] == 2'b00);
    assign bank_idx    = ar_off[IDX_W+1:2];
    assign bank_rd_req = (s_q.rd_st == RD_REQ) && ar_energy;

    // ==========================================================
    // zero-crossing period counter
    always_comb begin
        logic [2:0]  zsel;
        logic [16:0] cnt_nx;
        zsel   = zx_pulse & s_q.mode[ZX_SEL_LSB +: NUM_PH];
        cnt_nx = {1'b0, s_q.zx_cnt} + {16'h0000, zsel[0]}
               + {16'h0000, zsel[1]} + {16'h0000, zsel[2]};
        period_end = (|s_q.mode[LC_APPARENT_BIT:LC_ACTIVE_BIT]) &&
                     (s_q.lc_len != 16'h0000) &&
                     (cnt_nx >= {1'b0, s_q.lc_len});
    end

    // ==========================================================
    // next state: flags, bus slave, interrupt
    always_comb begin
        logic [31:0] set;
        logic [31:0] clr;
        logic [31:0] wd;
        eamc_pwr_t   pa;
        eamc_pwr_t   pr;
        set = '0;
        clr = '0;
        wd  = '0;
        pa  = '0;
        pr  = '0;
        s_d = s_q;

        // counter restarts at each period end or outside line-cycle
        if (!(|s_q.mode[LC_APPARENT_BIT:LC_ACTIVE_BIT]) || period_end)
            s_d.zx_cnt = '0;
        else
            s_d.zx_cnt = s_q.zx_cnt + {15'h0000, zx_pulse[0] &
                         s_q.mode[ZX_SEL_LSB]} + {15'h0000, zx_pulse[1] &
                         s_q.mode[ZX_SEL_LSB+1]} + {15'h0000, zx_pulse[2] &
                         s_q.mode[ZX_SEL_LSB+2]};

        // reverse power flags from the selected power source
        if (sample.valid) begin
            for (int p = 0; p < NUM_PH; p++) begin
                pa = s_q.acfg[REV_ACT_SEL_BIT] ? sample.pwr[IDX_FACT+p]
                                               : sample.pwr[IDX_ACT+p];
                pr = s_q.acfg[REV_REACT_SEL_BIT] ? sample.pwr[IDX_FREACT+p]
                                                 : sample.pwr[IDX_REACT+p];
                set[ST_REV_ACT_LSB+p]   = pa[PWR_W-1];
                set[ST_REV_REACT_LSB+p] = pr[PWR_W-1];
            end
        end
        set[ST_LC_DONE_BIT] = period_end;

        // write response drains
        if (s_q.bvalid && bready)
            s_d.bvalid = 1'b0;

        // both halves held: perform the write
        if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = RESP_OKAY;
            unique case ({s_q.aw_addr[ADDR_W-1:2], 2'b00})
                MODE_ADDR: begin
                    wd = wmerge({24'h000000, s_q.mode}, s_q.w_data,
                                s_q.w_strb);
                    s_d.mode = wd[7:0] & MODE_WMASK;
                end
                ACFG_ADDR: begin
                    wd = wmerge({24'h000000, s_q.acfg}, s_q.w_data,
                                s_q.w_strb);
                    s_d.acfg = wd[7:0] & ACFG_WMASK;
                end
                MASK_ADDR:
                    s_d.mask = wmerge(s_q.mask, s_q.w_data, s_q.w_strb);
                STATUS_ADDR:
                    clr = wmerge(32'h00000000, s_q.w_data, s_q.w_strb);
                LCLEN_ADDR: begin
                    wd = wmerge({16'h0000, s_q.lc_len}, s_q.w_data,
                                s_q.w_strb);
                    s_d.lc_len = wd[15:0];
                end
                default: begin
                    // energy slots are read only; writes ignored
                    if (!((s_q.aw_addr >= ENERGY_BASE) &&
                          (s_q.aw_addr <= ENERGY_END)))
                        s_d.bresp = RESP_SLVERR;
                end
            endcase
        end

        // accept address and data in either order
        if (awvalid && s_q.awready) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.w_held = 1'b1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
        end
        s_d.awready = !s_d.aw_held;
        s_d.wready  = !s_d.w_held;

        // sticky status: a new event wins over a same-cycle clear
        s_d.status = (s_q.status & ~clr) | set;

        // read channel
        unique case (s_q.rd_st)
            RD_IDLE: begin
                if (arvalid) begin
                    s_d.ar_addr = araddr;
                    s_d.arready = 1'b0;
                    s_d.rd_st   = RD_REQ;
                end
            end
            RD_REQ:
                s_d.rd_st = RD_CAP;
            RD_CAP: begin
                s_d.rvalid = 1'b1;
                s_d.rresp  = RESP_OKAY;
                s_d.rd_st  = RD_RESP;
                if (ar_energy)
                    s_d.rdata = bank_data;
                else begin
                    unique case ({s_q.ar_addr[ADDR_W-1:2], 2'b00})
                        MODE_ADDR:   s_d.rdata = {24'h000000, s_q.mode};
                        ACFG_ADDR:   s_d.rdata = {24'h000000, s_q.acfg};
                        MASK_ADDR:   s_d.rdata = s_q.mask;
                        STATUS_ADDR: s_d.rdata = s_q.status;
                        LCLEN_ADDR:  s_d.rdata = {16'h0000, s_q.lc_len};
                        default: begin
                            s_d.rdata = 32'h00000000;
                            s_d.rresp = RESP_SLVERR;
                        end
                    endcase
                end
            end
            RD_RESP: begin
                if (rready) begin
                    s_d.rvalid  = 1'b0;
                    s_d.arready = 1'b1;
                    s_d.rd_st   = RD_IDLE;
                end
            end
            default: begin
                s_d.rd_st   = RD_IDLE;
                s_d.arready = 1'b1;
                s_d.rvalid  = 1'b0;
            end
        endcase

        s_d.irq = |(s_d.status & s_d.mask);
    end

    // ==========================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q         <= '0;
            s_q.mode    <= MODE_RESET;
            s_q.acfg    <= ACFG_RESET;
            s_q.mask    <= MASK_RESET;
            s_q.lc_len  <= LCLEN_RESET;
            s_q.rd_st   <= RD_IDLE;
            s_q.awready <= 1'b1;
            s_q.wready  <= 1'b1;
            s_q.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // accumulator bank
    eamc_acc_bank u_bank (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .sample     (sample),
        .lc_mode    (lc_vec),
        .period_end (period_end),
        .rd_req     (bank_rd_req),
        .rd_idx     (bank_idx),
        .rd_clear   (s_q.mode[READ_CLR_BIT]),
        .rd_data    (bank_data)
    );

    assign awready = s_q.awready;
    assign wready  = s_q.wready;
    assign bvalid  = s_q.bvalid;
    assign bresp   = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid  = s_q.rvalid;
    assign rdata   = s_q.rdata;
    assign rresp   = s_q.rresp;
    assign irq     = s_q.irq;

    // ==========================================================
    // checks
    a_mode_reset: assert property (@(posedge aclk)
        $rose(aresetn) |-> s_q.mode == 8'h78)
        else $error("mode control reset value wrong");
    a_rev_act_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sample.valid && !s_q.acfg[6] && sample.pwr[0][23] |=> s_q.status[6])
        else $error("phase a reverse active flag missed");
    a_rev_act_bc: assert property (@(posedge aclk) disable iff (!aresetn)
        sample.valid && !s_q.acfg[6] && sample.pwr[1][23] && sample.pwr[2][23]
        |=> s_q.status[7] && s_q.status[8])
        else $error("phase b or c reverse active flag missed");
    a_rev_var_tot: assert property (@(posedge aclk) disable iff (!aresetn)
        sample.valid && !s_q.acfg[7] && sample.pwr[7][23] && !s_q.status[11]
        |=> s_q.status[11])
        else $error("total reactive b flag missed");
    a_rev_var_fund: assert property (@(posedge aclk) disable iff (!aresetn)
        sample.valid && s_q.acfg[7] && !sample.pwr[11][23] && !s_q.status[12]
        && !(s_q.aw_held && s_q.w_held)
        |=> !s_q.status[12])
        else $error("reactive c flag not from fundamental power");
    a_zx_count: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.mode[0] && s_q.mode[5:3] == 3'b111 && zx_pulse == 3'b111
        && !period_end |=> s_q.zx_cnt == $past(s_q.zx_cnt) + 16'h0003)
        else $error("crossings of all selected phases not counted");
    a_zx_masked: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.mode[0] && s_q.mode[5:3] == 3'b000 && !period_end
        |=> s_q.zx_cnt == $past(s_q.zx_cnt))
        else $error("deselected phase crossing was counted");
    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == |(s_q.status & s_q.mask))
        else $error("interrupt does not follow masked status");

endmodule : eamc_top

`default_nettype wire

// [hdl/eamc_pkg.sv]
package eamc_pkg;

    // ==========================================================
    // widths and counts
    localparam int ADDR_W  = 20;
    localparam int DATA_W  = 32;
    localparam int PWR_W   = 24;
    localparam int ACC_W   = 32;
    localparam int NUM_ACC = 15;
    localparam int NUM_PH  = 3;
    localparam int IDX_W   = 4;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [ADDR_W-1:0] MODE_IDX    = 20'h0e702;
    localparam logic [ADDR_W-1:0] MODE_ADDR   = {MODE_IDX[17:0], 2'b00};
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 20'h00000;
    localparam logic [ADDR_W-1:0] MASK_ADDR   = 20'h00004;
    localparam logic [ADDR_W-1:0] ACFG_ADDR   = 20'h00008;
    localparam logic [ADDR_W-1:0] LCLEN_ADDR  = 20'h0000c;
    localparam logic [ADDR_W-1:0] ENERGY_BASE = 20'h00100;
    localparam logic [ADDR_W-1:0] ENERGY_END  = 20'h0013c;

    // ==========================================================
    // line_cycle_mode_control fields
    localparam int LC_ACTIVE_BIT   = 0;
    localparam int LC_REACTIVE_BIT = 1;
    localparam int LC_APPARENT_BIT = 2;
    localparam int ZX_SEL_LSB      = 3;
    localparam int READ_CLR_BIT    = 6;
    localparam logic [7:0] MODE_RESET = 8'h78;
    localparam logic [7:0] MODE_WMASK = 8'h7f;

    // ==========================================================
    // accumulation configuration fields
    localparam int REV_ACT_SEL_BIT   = 6;
    localparam int REV_REACT_SEL_BIT = 7;
    localparam logic [7:0] ACFG_RESET = 8'h00;
    localparam logic [7:0] ACFG_WMASK = 8'hc0;

    // ==========================================================
    // primary_status_word fields
    localparam int ST_LC_DONE_BIT   = 5;
    localparam int ST_REV_ACT_LSB   = 6;
    localparam int ST_REV_REACT_LSB = 10;
    localparam logic [31:0] MASK_RESET   = 32'h00000000;
    localparam logic [15:0] LCLEN_RESET  = 16'h0064;

    // ==========================================================
    // accumulator slots: phases a, b, c in each group
    localparam int IDX_ACT    = 0;
    localparam int IDX_FACT   = 3;
    localparam int IDX_REACT  = 6;
    localparam int IDX_FREACT = 9;
    localparam int IDX_APP    = 12;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ==========================================================
    // types
    typedef logic signed [PWR_W-1:0] eamc_pwr_t;

    typedef struct packed {
        logic                      valid;
        eamc_pwr_t [NUM_ACC-1:0]   pwr;
    } eamc_sample_s;

    typedef enum logic [3:0] {
        RD_IDLE = 4'b0001,
        RD_REQ  = 4'b0010,
        RD_CAP  = 4'b0100,
        RD_RESP = 4'b1000
    } eamc_rd_e;

endpackage : eamc_pkg

// [hdl/eamc_acc_bank.sv]
`timescale 1ns/1ps
`default_nettype none

module eamc_acc_bank
    import eamc_pkg::*;
(
    input  wire logic                        aclk,       // core clock
    input  wire logic                        aresetn,    // sync reset
    input  wire eamc_pkg::eamc_sample_s      sample,     // power samples
    input  wire logic [eamc_pkg::NUM_ACC-1:0] lc_mode,   // line-cycle per slot
    input  wire logic                        period_end, // line period over
    input  wire logic                        rd_req,     // read one slot
    input  wire logic [eamc_pkg::IDX_W-1:0]  rd_idx,     // slot to read
    input  wire logic                        rd_clear,   // clear on read
    output logic [eamc_pkg::ACC_W-1:0]       rd_data     // registered value
);
    import eamc_pkg::*;

    typedef struct packed {
        logic [NUM_ACC-1:0][ACC_W-1:0] vis;
        logic [NUM_ACC-1:0][ACC_W-1:0] lc;
        logic [ACC_W-1:0]              rd_data;
    } eamc_bank_s;

    eamc_bank_s s_q;
    eamc_bank_s s_d;

    // ==========================================================
    // accumulation per slot
    always_comb begin
        logic [ACC_W-1:0] add;
        logic [ACC_W-1:0] lsum;
        logic             hit;
        add  = '0;
        lsum = '0;
        hit  = 1'b0;
        s_d  = s_q;
        for (int i = 0; i < NUM_ACC; i++) begin
            add = sample.valid ?
                  {{(ACC_W-PWR_W){sample.pwr[i][PWR_W-1]}}, sample.pwr[i]}
                  : '0;
            hit = rd_req && (rd_idx == IDX_W'(i)) && rd_clear;
            if (lc_mode[i]) begin
                // partial sum stays hidden until the period closes
                lsum = s_q.lc[i] + add;
                if (period_end) begin
                    s_d.vis[i] = lsum;
                    s_d.lc[i]  = '0;
                end else begin
                    s_d.lc[i] = lsum;
                    if (hit)
                        s_d.vis[i] = '0;
                end
            end else begin
                // stale partial dropped so a mode flip never spoils vis
                s_d.lc[i]  = '0;
                s_d.vis[i] = (hit ? '0 : s_q.vis[i]) + add;
            end
        end
        if (rd_req)
            s_d.rd_data = (rd_idx < IDX_W'(NUM_ACC)) ? s_q.vis[rd_idx] : '0;
    end

    // ==========================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign rd_data = s_q.rd_data;

    // ==========================================================
    // checks
    a_lc_watt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        lc_mode[IDX_ACT] && !period_end && !(rd_req && rd_idx == 4'h0)
        |=> s_q.vis[IDX_ACT] == $past(s_q.vis[IDX_ACT]))
        else $error("line-cycle watt slot moved before period end");
    a_lc_var_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        lc_mode[IDX_REACT] && !period_end && !(rd_req && rd_idx == 4'h6)
        |=> s_q.vis[IDX_REACT] == $past(s_q.vis[IDX_REACT]))
        else $error("line-cycle var slot moved before period end");
    a_lc_va_load: assert property (@(posedge aclk) disable iff (!aresetn)
        lc_mode[IDX_APP] && period_end && !sample.valid
        |=> s_q.vis[IDX_APP] == $past(s_q.lc[IDX_APP]) && s_q.lc[IDX_APP] == '0)
        else $error("line-cycle va slot not loaded at period end");
    a_rd_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_req && !rd_clear && rd_idx == 4'h1 && !sample.valid && !lc_mode[1]
        |=> s_q.vis[1] == $past(s_q.vis[1]) && rd_data == $past(s_q.vis[1]))
        else $error("read without clear changed the slot");
    a_rd_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_req && rd_clear && rd_idx == 4'h2 && !sample.valid && !lc_mode[2]
        |=> s_q.vis[2] == '0 && rd_data == $past(s_q.vis[2]))
        else $error("read with clear did not return then clear");
    a_mode_flip: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(lc_mode[IDX_APP]) && !sample.valid && !period_end && !rd_req
        |=> s_q.vis[IDX_APP] == $past(s_q.vis[IDX_APP]))
        else $error("mode change disturbed stored energy");

endmodule : eamc_acc_bank

`default_nettype wire

// [bench/energy_accum_mode_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e) begin checks_done++; if ((g)!==(e)) begin num_errors++; \
$display("CHECK FAILED t=%0t got %h exp %h",$time,g,e); end end
module energy_accum_mode_control_test;
    import eamc_pkg::*;
    // ====
    // signals and model state
    logic aclk=0, aresetn=0, awvalid=0, wvalid=0, bready=0, arvalid=0;
    logic rready=0, awready, wready, bvalid, arready, rvalid, irq;
    logic [ADDR_W-1:0] awaddr='0, araddr='0;
    logic [DATA_W-1:0] wdata='0, rdata;
    logic [3:0]   wstrb=4'hf;
    logic [1:0]   bresp, rresp;
    logic [2:0]   zx_pulse=3'h0;
    logic [31:0]  st;
    eamc_sample_s sample='0;
    int num_errors=0, checks_done=0, acc[NUM_ACC], v[NUM_ACC];
    // clock and device
    always #25 aclk = ~aclk;
    eamc_top i_eamc_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .sample(sample), .zx_pulse(zx_pulse), .irq(irq));
    // ====
    // bus tasks: each channel held until its own ready edge
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 0;
        w = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            aw |= awvalid & awready;
            w |= wvalid & wready;
            awvalid <= awvalid & ~awready;
            wvalid <= wvalid & ~wready;
        end while (!(aw & w));
        while (!bvalid) @(posedge aclk);
        bready <= 1'b0;
        `CHK(bresp, RESP_OKAY)
    endtask : wr
    task automatic rd(input logic [19:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        `CHK(rdata, e)
        `CHK(rresp, er)
    endtask : rd
    // one sample; neg picks signed values, else small positive ones
    task automatic samp(input int neg);
        @(posedge aclk);
        for (int i = 0; i < NUM_ACC; i++) begin
            // kept apart: a mixed ?: would make the signed draw unsigned
            if (neg)
                v[i] = $signed($urandom) >>> 9;
            else
                v[i] = $urandom_range(1, 'hfffff);
            sample.pwr[i] <= v[i][PWR_W-1:0];
            acc[i] += v[i];
        end
        sample.valid <= 1'b1;
        @(posedge aclk);
        sample.valid <= 1'b0;
    endtask : samp
    task automatic zx(input logic [2:0] p);
        @(posedge aclk);
        zx_pulse <= p;
        @(posedge aclk);
        zx_pulse <= 3'h0;
    endtask : zx
    task automatic stop_test();
        $display("counts: %0d checks, %0d errors", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    // ====
    // watchdog: about twenty times the expected run
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end
    // main sequence
    initial begin
        void'($urandom(77808));
        foreach (acc[i]) acc[i] = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(MODE_ADDR, 32'h78, RESP_OKAY);
        rd(ACFG_ADDR, 32'h0, RESP_OKAY);
        rd(20'h00ff0, 32'h0, RESP_SLVERR);
        $display("test reset done");
        samp(0);
        rd(ENERGY_BASE, acc[0], RESP_OKAY);
        acc[0] = 0;
        rd(ENERGY_BASE, 32'h0, RESP_OKAY);
        rd(ENERGY_BASE + 20'h8, acc[2], RESP_OKAY);
        acc[2] = 0;
        wr(MODE_ADDR, 32'hb8);
        rd(MODE_ADDR, 32'h38, RESP_OKAY);
        samp(0);
        rd(ENERGY_BASE, acc[0], RESP_OKAY);
        rd(ENERGY_BASE + 20'h4, acc[1], RESP_OKAY);
        rd(ENERGY_BASE + 20'h30, acc[12], RESP_OKAY);
        rd(ENERGY_BASE + 20'h30, acc[12], RESP_OKAY);
        $display("test read clear done");
        // every source select combination, flags and interrupt
        wr(MASK_ADDR, 32'h1dc0);
        for (int s = 0; s < 4; s++) begin
            wr(ACFG_ADDR, 32'(s << 6));
            wr(STATUS_ADDR, 32'hffffffff);
            samp(1);
            st = 0;
            for (int p = 0; p < 3; p++) begin
                st[6+p] = v[s[0] ? 3+p : p] < 0;
                st[10+p] = v[s[1] ? 9+p : 6+p] < 0;
            end
            rd(STATUS_ADDR, st, RESP_OKAY);
            `CHK(irq, |(st & 32'h1dc0))
        end
        $display("test reverse flags done");
        // period of two crossings: no phase selected, then phase a only for two pulses
        wr(LCLEN_ADDR, 32'h2);
        wr(MODE_ADDR, 32'h01);
        wr(STATUS_ADDR, 32'hffffffff);
        zx(3'h7);
        rd(STATUS_ADDR, 32'h0, RESP_OKAY);
        wr(MODE_ADDR, 32'h09);
        zx(3'h7);
        rd(STATUS_ADDR, 32'h0, RESP_OKAY);
        zx(3'h7);
        rd(STATUS_ADDR, 32'h20, RESP_OKAY);
        // period of four crossings, all groups line-cycle, one sample
        wr(STATUS_ADDR, 32'hffffffff);
        wr(LCLEN_ADDR, 32'h4);
        wr(MODE_ADDR, 32'h3f);
        samp(0);
        zx(3'h7);
        rd(STATUS_ADDR, 32'h0, RESP_OKAY);
        zx(3'h1);
        rd(STATUS_ADDR, 32'h20, RESP_OKAY);
        rd(ENERGY_BASE + 20'h30, v[12], RESP_OKAY);
        $display("test line cycle done");
        stop_test();
    end
endmodule : energy_accum_mode_control_test
`default_nettype wire
